// ===== design/eight_bit_port_timer_mux.sv
// Eight-bit general purpose port whose pins are shared with timer channels.
// Assumes one 50 MHz clock, pins synchronous to it, an AXI4-Lite master,
// and a timer pulse unit that supplies per-pin compare and capture selects.
//
// Decided for this implementation: register access over AXI4-Lite.
`include "port_mux_params.svh"

module eight_bit_port_timer_mux
  import port_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Power state
  input  wire logic                    hw_standby,
  input  wire logic                    soft_standby,
  // AXI4-Lite write address and data
  input  wire logic [`PM_ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [`PM_DATA_W-1:0]   wdata,
  input  wire logic [`PM_STRB_W-1:0]   wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // AXI4-Lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read
  input  wire logic [`PM_ADDR_W-1:0]   araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [`PM_DATA_W-1:0]        rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Port pins, bit 0-3 timer_a_capcomp_pin, 4-5 timer_b, 6-7 timer_c
  input  wire logic [`PM_PORT_W-1:0]   pin_in,
  output logic [`PM_PORT_W-1:0]        pin_out,
  output logic [`PM_PORT_W-1:0]        pin_oe,
  // Timer pulse unit side, one bit per pin
  input  wire logic [`PM_PORT_W-1:0]   oc_enable,
  input  wire logic [`PM_PORT_W-1:0]   oc_level,
  input  wire logic [`PM_PORT_W-1:0]   capture_select,
  output logic [`PM_PORT_W-1:0]        capture_in
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`PM_PORT_W-1:0]  pin_direction;
  logic [`PM_PORT_W-1:0]  pin_data_latch;
  logic [`PM_PORT_W-1:0]  oc_active;
  logic [`PM_PORT_W-1:0]  cap_active;
  logic [`PM_PORT_W-1:0]  port_read;
  logic [`PM_ADDR_W-1:0]  aw_addr_held;
  logic [`PM_DATA_W-1:0]  w_data_held;
  logic [`PM_STRB_W-1:0]  w_strb_held;
  logic                   aw_held;
  logic                   w_held;
  logic                   aw_hs;
  logic                   w_hs;
  logic                   ar_hs;
  logic                   have_aw;
  logic                   have_w;
  logic                   do_write;
  logic [`PM_ADDR_W-1:0]  wr_addr;
  logic [`PM_DATA_W-1:0]  wr_data;
  logic [`PM_STRB_W-1:0]  wr_strb;
  reg_sel_t               wr_sel;
  reg_sel_t               rd_sel;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_bvalid;
  logic                   next_rvalid;

  // Address decode, shared by the read and write paths
  function automatic reg_sel_t decode(input logic [`PM_ADDR_W-1:0] addr);
    if (addr == `PM_DIR_ADDR) begin
      return SEL_DIR;
    end else if (addr == `PM_LATCH_ADDR) begin
      return SEL_LATCH;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Timer function selection
  // ----------------------------------------------------------------
  // software standby drops timer use
  assign oc_active  = soft_standby ? '0 : oc_enable;
  assign cap_active = soft_standby ? '0 : capture_select;

  // Value seen by software on a data read; per-pin source
  // output not under compare reads latch
  assign port_read = (pin_direction & ~oc_active & pin_data_latch)
                   | ((~pin_direction | oc_active) & pin_in);

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is parked
  assign aw_hs        = awvalid & awready;
  assign w_hs         = wvalid & wready;
  assign have_aw      = aw_held | aw_hs;
  assign have_w       = w_held | w_hs;
  assign do_write     = have_aw & have_w;
  assign wr_addr      = aw_held ? aw_addr_held : awaddr;
  assign wr_data      = w_held ? w_data_held : wdata;
  assign wr_strb      = w_held ? w_strb_held : wstrb;
  assign wr_sel       = decode(wr_addr);
  assign next_aw_held = have_aw & ~do_write;
  assign next_w_held  = have_w & ~do_write;
  assign next_bvalid  = do_write | (bvalid & ~bready);

  // Parked write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_held <= '0;
      w_data_held  <= '0;
      w_strb_held  <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_hs) begin
        aw_addr_held <= awaddr;
      end
      if (w_hs) begin
        w_data_held <= wdata;
        w_strb_held <= wstrb;
      end
    end
  end

  // Ready stays low while a response waits, so one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= ~next_aw_held & ~next_bvalid;
      wready  <= ~next_w_held & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (do_write) begin
        bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  // direction clears on reset or hardware standby
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_direction <= `PM_DIR_RESET;
    end else if (do_write && wr_sel == SEL_DIR && wr_strb[0]) begin
      pin_direction <= wr_data[`PM_PORT_W-1:0];
    end
  end

  // latch clears on reset or hardware standby
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_data_latch <= `PM_LATCH_RESET;
    end else if (do_write && wr_sel == SEL_LATCH && wr_strb[0]) begin
      pin_data_latch <= wr_data[`PM_PORT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_hs       = arvalid & arready;
  assign rd_sel      = decode(araddr);
  assign next_rvalid = ar_hs | (rvalid & ~rready);

  // Data is captured at the address handshake and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_hs) begin
        case (rd_sel)
          SEL_DIR: begin
            rdata <= {24'h000000, `PM_DIR_READ};
            rresp <= RESP_OKAY;
          end
          SEL_LATCH: begin
            rdata <= {24'h000000, port_read};
            rresp <= RESP_OKAY;
          end
          default: begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and timer drive
  // ----------------------------------------------------------------
  // One register stage on every pin; the pin lags a write by a cycle
  // compare overrides direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      capture_in <= '0;
    end else begin
      pin_oe     <= pin_direction | oc_active;
      pin_out    <= (oc_active & oc_level) | (~oc_active & pin_data_latch);
      capture_in <= cap_active
                  & ((pin_direction & pin_data_latch) | (~pin_direction & pin_in));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_DIR_DRIVES_PIN: assert property (
    (pin_oe & ~$past(oc_active)) == ($past(pin_direction) & ~$past(oc_active)))
    else $error("pin enable does not follow direction");

  AST_DIR_READS_ONES: assert property (
    (arvalid && arready && araddr == `PM_DIR_ADDR)
      |=> rvalid && rdata == 32'h000000FF && rresp == RESP_OKAY)
    else $error("direction read is not all ones");

  AST_DIR_RESET: assert property (disable iff (1'b0)
    (!aresetn || hw_standby) |=> pin_direction == 8'h00)
    else $error("direction not cleared");

  AST_LATCH_RESET: assert property (disable iff (1'b0)
    (!aresetn || hw_standby) |=> pin_data_latch == 8'h00)
    else $error("latch not cleared");

  AST_OUT_READS_LATCH: assert property (
    (arvalid && arready && araddr == `PM_LATCH_ADDR)
      |=> ((rdata[7:0] ^ $past(pin_data_latch))
           & $past(pin_direction & ~oc_active)) == 8'h00)
    else $error("output pin read does not return latch");

  AST_IN_READS_PIN: assert property (
    (arvalid && arready && araddr == `PM_LATCH_ADDR)
      |=> ((rdata[7:0] ^ $past(pin_in)) & ~$past(pin_direction)) == 8'h00)
    else $error("input pin read does not return pin level");

  AST_OC_DRIVES: assert property (
    1'b1 |=> (pin_oe & $past(oc_active)) == $past(oc_active)
             && (pin_out & $past(oc_active)) == ($past(oc_level) & $past(oc_active)))
    else $error("compare output not on pin");

  AST_OC_READS_PIN: assert property (
    (arvalid && arready && araddr == `PM_LATCH_ADDR)
      |=> ((rdata[7:0] ^ $past(pin_in)) & $past(oc_active)) == 8'h00)
    else $error("compare pin read does not return pin level");

  AST_CAP_OUT_FEED: assert property (
    1'b1 |=> (capture_in & $past(cap_active & pin_direction))
             == ($past(pin_data_latch) & $past(cap_active & pin_direction)))
    else $error("capture output not fed back to timer");

  AST_CAP_IN_FEED: assert property (
    1'b1 |=> (capture_in & $past(cap_active & ~pin_direction))
             == ($past(pin_in) & $past(cap_active & ~pin_direction)))
    else $error("capture input not passed to timer");

  AST_STANDBY_PLAIN: assert property (
    soft_standby |=> pin_oe == $past(pin_direction)
                     && pin_out == $past(pin_data_latch) && capture_in == 8'h00)
    else $error("timer still active in software standby");

  AST_WRITE_ONE_RESP: assert property (
    (bvalid && !bready) |=> bvalid && !awready && !wready)
    else $error("write response dropped early");

  AST_READ_HOLD: assert property (
    (rvalid && !rready) |=> rvalid && $stable(rdata) && !arready)
    else $error("read data not held");

endmodule

// ===== design/port_mux_params.svh
// Constants for the eight-bit port shared with the timer pulse unit.
// Assumes a 32-bit AXI4-Lite bus with 20-bit byte addresses.
`ifndef PORT_MUX_PARAMS_SVH
`define PORT_MUX_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 x index)
// ----------------------------------------------------------------
`define PM_ADDR_W        20
`define PM_DIR_IDX       18'h0FE88
`define PM_LATCH_IDX     18'h0FE8A
`define PM_DIR_ADDR      {`PM_DIR_IDX, 2'b00}
`define PM_LATCH_ADDR    {`PM_LATCH_IDX, 2'b00}

// ----------------------------------------------------------------
// Widths, reset values and fixed read values
// ----------------------------------------------------------------
`define PM_PORT_W        8
`define PM_DIR_RESET     8'h00
`define PM_LATCH_RESET   8'h00
`define PM_DIR_READ      8'hFF
`define PM_DATA_W        32
`define PM_STRB_W        4

`endif

// ===== design/port_mux_pkg.sv
// Types shared by the port block and its bench.
// Assumes the constants header is compiled alongside.
package port_mux_pkg;

  // ----------------------------------------------------------------
  // Bus answer codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

  // ----------------------------------------------------------------
  // Register selected by an address
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_DIR   = 2'b01,
    SEL_LATCH = 2'b10
  } reg_sel_t;

endpackage

// ===== dv/pin_timer_model.sv
// Model of the pins and the timer pulse unit around the port block.
// Assumes the bench commands the timer selects and the external pin level.
module pin_timer_model (
  // Clock
  input  wire logic       aclk,
  // Port drive from the block
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Bench commands
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] oc_en_cmd,
  input  wire logic [7:0] oc_lvl_cmd,
  input  wire logic [7:0] cap_cmd,
  // Pin level and timer selects
  output logic      [7:0] pin_in,
  output logic      [7:0] oc_enable,
  output logic      [7:0] oc_level,
  output logic      [7:0] capture_select
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wire level: the block wins where it drives, else the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // timer select outputs
  // Registered so selects change just after an edge, like the real unit
  always_ff @(posedge aclk) begin
    oc_enable      <= oc_en_cmd;
    oc_level       <= oc_lvl_cmd;
    capture_select <= cap_cmd;
  end
endmodule

// ===== dv/tb_eight_bit_port_timer_mux.sv
// Self-checking bench for the eight-bit port shared with timer channels.
// Assumes the constants header and package are compiled first.
`include "port_mux_params.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb_eight_bit_port_timer_mux
  import port_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, hw_standby, soft_standby;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  pin_in, pin_out, pin_oe, oc_enable, oc_level, capture_select, capture_in;
  logic [7:0]  ext, oc_en, oc_lvl, cap;
  int          failures, cmp_count;

  eight_bit_port_timer_mux dut (
    .aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby), .soft_standby(soft_standby),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .oc_enable(oc_enable),
    .oc_level(oc_level), .capture_select(capture_select), .capture_in(capture_in));

  pin_timer_model partner (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .oc_en_cmd(oc_en), .oc_lvl_cmd(oc_lvl), .cap_cmd(cap), .pin_in(pin_in),
    .oc_enable(oc_enable), .oc_level(oc_level), .capture_select(capture_select));

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Address and data go out together; each valid drops at the edge that takes it.
  // No local limit: a hang is ended by the watchdog only
  task automatic wrc(input logic [19:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rdc(input string nm, input logic [19:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(nm, e, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // Timer selects pass the model's register and then the block's: two edges
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Watchdog well beyond the fewer than one hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    results();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, hw_standby, soft_standby, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {oc_en, oc_lvl, cap} = '0;
    ext = 8'h5A;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("dir read", `PM_DIR_ADDR, 32'h000000FF, RESP_OKAY);
    rdc("latch input", `PM_LATCH_ADDR, 32'h0000005A, RESP_OKAY);
    wrc(`PM_LATCH_ADDR, 8'hC3, RESP_OKAY);
    settle();
    `CHK("oe input", 8'h00, pin_oe)
    rdc("latch input", `PM_LATCH_ADDR, 32'h0000005A, RESP_OKAY);
    wrc(`PM_DIR_ADDR, 8'h0F, RESP_OKAY);
    settle();
    `CHK("oe mixed", 8'h0F, pin_oe)
    `CHK("out mixed", 8'h03, pin_out & 8'h0F)
    rdc("latch mixed", `PM_LATCH_ADDR, 32'h00000053, RESP_OKAY);
    rdc("dir read", `PM_DIR_ADDR, 32'h000000FF, RESP_OKAY);
    // Compare owns bits 0,4,5; bit 0 level opposes its latch bit
    oc_en  <= 8'h31;
    oc_lvl <= 8'h10;
    settle();
    `CHK("oe compare", 8'h3F, pin_oe)
    `CHK("out compare", 8'h12, pin_out & 8'h3F)
    rdc("latch compare", `PM_LATCH_ADDR, 32'h00000052, RESP_OKAY);
    oc_en <= 8'h00;
    cap   <= 8'hC3;
    settle();
    `CHK("capture", 8'h43, capture_in)
    `CHK("oe capture", 8'h0F, pin_oe)
    @(posedge aclk);
    soft_standby <= 1'b1;
    oc_en        <= 8'h31;
    settle();
    `CHK("capture standby", 8'h00, capture_in)
    `CHK("oe standby", 8'h0F, pin_oe)
    `CHK("out standby", 8'h03, pin_out & 8'h0F)
    rdc("latch kept", `PM_LATCH_ADDR, 32'h00000053, RESP_OKAY);
    {soft_standby, oc_en, cap} <= '0;
    hw_standby <= 1'b1;
    settle();
    `CHK("oe hw standby", 8'h00, pin_oe)
    @(posedge aclk);
    hw_standby <= 1'b0;
    wrc(`PM_DIR_ADDR, 8'hFF, RESP_OKAY);
    settle();
    `CHK("out cleared", 8'h00, pin_out)
    `CHK("oe all", 8'hFF, pin_oe)
    rdc("latch cleared", `PM_LATCH_ADDR, 32'h00000000, RESP_OKAY);
    wrc(20'h00010, 8'hA5, RESP_SLVERR);
    rdc("unmapped", 20'h00010, 32'h00000000, RESP_SLVERR);
    // Low byte strobe off: the write is answered but changes nothing
    wstrb <= 4'hE;
    wrc(`PM_LATCH_ADDR, 8'hFF, RESP_OKAY);
    wstrb <= 4'hF;
    settle();
    `CHK("out no write", 8'h00, pin_out)
    rdc("latch no strobe", `PM_LATCH_ADDR, 32'h00000000, RESP_OKAY);
    results();
  end
endmodule
